// *** logic/trace_buffer_master_control.sv ***
// Trace buffer master control: enable, start/stop, watermark, privilege
// gating, circular pointer and trace RAM, plus its packet FIFO.
// Assumes rst_b may be asynchronous and all other inputs are synchronous.
`timescale 1ns/1ps

module trace_fifo
   import trace_pkg::*;
#(
   parameter int WIDTH = 64,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_sync_b,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   // Occupancy; pushes and pops may share a cycle
   always_comb begin
      next_count = count;
      if (push && !pop) next_count = count + CW'(1);
      if (pop && !push) next_count = count - CW'(1);
   end

   // Flags are registered so ready reaches the source from a flop
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         count <= next_count;
         in_ready <= (next_count != FULL);
         out_valid <= (next_count != '0);
         if (push) wr_ptr <= bump(wr_ptr);
         if (pop) rd_ptr <= bump(rd_ptr);
      end
   end

   // Storage, no reset needed
   always_ff @(posedge clk_sys) begin
      if (push) mem[wr_ptr] <= in_data;
   end
endmodule

// Notes on behaviour
// - Enabled: write packet at pointer, then advance
// - Watermark hit with auto stop clears enable
// - Start input with its enable sets enable
// - Stop input with its enable clears enable; packet write finishes
// - After watermark stop, start ignored until changed
// - Bits 30 to 10 read as zero
// - Halt output needs halt bit and debug enable
// - Watermark hit with auto halt sets halt bit
// - RAM privilege bit: user RAM access RAZ/WI
// - HPROT bit 1 marks privileged access
// - Write privilege bit blocks user register writes
// - Mask limits increment; overflow wraps low bits
// - Buffer is circular, 2^(mask+4) bytes, aligned
// - Mask above maximum acts as maximum
// - Two-word packets, pointer bits 14:3 only
// - Pointer equal to watermark triggers actions
module trace_buffer_master_control
   import trace_pkg::*;
#(
   parameter int RAM_WORDS = TRACE_RAM_WORDS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Register and RAM access
   input wire bus_req_t bus_req,
   output logic bus_ack,
   output logic [31:0] bus_rdata,
   // Trace packet stream
   input wire logic trace_valid,
   input wire packet_t trace_packet,
   output logic trace_ready,
   // Position and flow settings
   input wire logic pos_wr,
   input wire logic [PTR_W-1:0] pos_wdata,
   input wire logic [PTR_W-1:0] watermark,
   input wire logic auto_stop,
   input wire logic auto_halt,
   output logic [PTR_W-1:0] trace_pointer,
   output logic trace_wrap,
   // Start, stop and debug
   input wire logic trace_start_in,
   input wire logic trace_stop_in,
   input wire logic invasive_debug_enable,
   output logic debug_halt_request_out
);
   logic rst_meta_b;
   logic rst_sync_b;
   // Master control fields
   logic trace_en;
   logic halt_request_bit;
   logic ram_privilege_only;
   logic register_write_privilege;
   logic stop_input_enable;
   logic start_input_enable;
   logic [MASK_W-1:0] mask;
   logic next_en;
   logic next_halt;
   logic [31:0] master_value;
   // Access decode
   logic privileged;
   logic reg_hit;
   logic reg_wr_ok;
   logic ram_ok;
   logic bus_ram_wr;
   // Writer
   write_state_t wstate;
   packet_t packet;
   logic fifo_valid;
   packet_t fifo_data;
   logic fifo_pop;
   logic stall;
   logic advance_now;
   logic [PTR_W:0] stepped;
   logic [31:0] ram [RAM_WORDS];
   logic [RAM_AW-1:0] trace_idx;
   // Watermark tracking
   logic wm_hit;
   logic wm_stopped;
   logic pos_wr_q;
   logic [PTR_W-1:0] watermark_q;

   function automatic logic [MASK_W-1:0] eff_mask(input logic [MASK_W-1:0] m);
      eff_mask = (m > MASK_MAX) ? MASK_MAX : m;
   endfunction

   // Carry out in the top bit; only bits up to the mask may change
   function automatic logic [PTR_W:0] step(input logic [PTR_W-1:0] p,
                                           input logic [MASK_W-1:0] m);
      logic [PTR_W:0] low;
      logic [PTR_W:0] sum;
      low = (13'h0001 << (eff_mask(m) + 5'h01)) - 13'h0001;
      sum = {1'b0, p & low[PTR_W-1:0]} + 13'h0001;
      step = {(sum & ~low) != 13'h0000,
              (p & ~low[PTR_W-1:0]) | (sum[PTR_W-1:0] & low[PTR_W-1:0])};
   endfunction

   // Release of reset through two flops
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // Access classification
   assign privileged = bus_req.prot[HPROT_PRIV_BIT];
   assign reg_hit = bus_req.valid && !bus_req.to_ram && (bus_req.addr == MASTER_OFFSET);
   assign reg_wr_ok = reg_hit && bus_req.write
                      && (privileged || !register_write_privilege);
   assign ram_ok = privileged || !ram_privilege_only;
   assign bus_ram_wr = bus_req.valid && bus_req.to_ram && bus_req.write && ram_ok;

   // Read image; unused bits stay zero
   always_comb begin
      master_value = '0;
      master_value[EN_BIT] = trace_en;
      master_value[HALT_BIT] = halt_request_bit;
      master_value[RAM_PRIVILEGE_ONLY_BIT] = ram_privilege_only;
      master_value[WPRIV_BIT] = register_write_privilege;
      master_value[STOPEN_BIT] = stop_input_enable;
      master_value[STARTEN_BIT] = start_input_enable;
      master_value[MASK_W-1:0] = mask;
   end

   assign wm_hit = (trace_pointer == watermark);

   // Enable: software, then start, then stops; stops win
   always_comb begin
      next_en = trace_en;
      if (reg_wr_ok) next_en = bus_req.wdata[EN_BIT];
      if (start_input_enable && trace_start_in && !wm_stopped) next_en = 1'b1;
      if (stop_input_enable && trace_stop_in) next_en = 1'b0;
      if (wm_hit && auto_stop) next_en = 1'b0;
   end

   // Halt bit: hardware set beats a software clear
   always_comb begin
      next_halt = halt_request_bit;
      if (reg_wr_ok) next_halt = bus_req.wdata[HALT_BIT];
      if (wm_hit && auto_halt) next_halt = 1'b1;
   end

   // Master control register
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         trace_en <= MASTER_RESET[EN_BIT];
         halt_request_bit <= MASTER_RESET[HALT_BIT];
         ram_privilege_only <= MASTER_RESET[RAM_PRIVILEGE_ONLY_BIT];
         register_write_privilege <= MASTER_RESET[WPRIV_BIT];
         stop_input_enable <= MASTER_RESET[STOPEN_BIT];
         start_input_enable <= MASTER_RESET[STARTEN_BIT];
         mask <= MASTER_RESET[MASK_W-1:0];
      end else begin
         trace_en <= next_en;
         halt_request_bit <= next_halt;
         if (reg_wr_ok) begin
            ram_privilege_only <= bus_req.wdata[RAM_PRIVILEGE_ONLY_BIT];
            register_write_privilege <= bus_req.wdata[WPRIV_BIT];
            stop_input_enable <= bus_req.wdata[STOPEN_BIT];
            start_input_enable <= bus_req.wdata[STARTEN_BIT];
            mask <= bus_req.wdata[MASK_W-1:0];
         end
      end
   end

   // Halt output follows the bit in the same cycle as it lands
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) debug_halt_request_out <= 1'b0;
      else debug_halt_request_out <= next_halt && invasive_debug_enable;
   end

   // Watermark stop latch; cleared a cycle after a pointer load so the
   // old pointer cannot re-arm it in the load cycle
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wm_stopped <= 1'b0;
         pos_wr_q <= 1'b0;
         watermark_q <= '0;
      end else begin
         pos_wr_q <= pos_wr;
         watermark_q <= watermark;
         if (pos_wr_q || watermark != watermark_q || !auto_stop) wm_stopped <= 1'b0;
         if (wm_hit && auto_stop) wm_stopped <= 1'b1;
      end
   end

   // Packet FIFO in front of the RAM writer
   trace_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) packet_fifo (
      .clk_sys(clk_sys),
      .rst_sync_b(rst_sync_b),
      .in_valid(trace_valid),
      .in_data(trace_packet),
      .in_ready(trace_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_pop)
   );

   // Bus RAM writes take the port; the writer waits a cycle
   assign stall = bus_ram_wr;
   // No new packet starts in a cycle whose stop or watermark clears enable
   assign fifo_pop = (wstate == W_IDLE) && trace_en && next_en && fifo_valid;
   assign advance_now = (wstate == W_SECOND) && !stall;
   assign stepped = step(trace_pointer, mask);
   assign trace_idx = (wstate == W_SECOND) ? {trace_pointer, 1'b1}
                                           : {trace_pointer, 1'b0};

   // Writer: a started packet always completes, even after a stop
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wstate <= W_IDLE;
         packet <= '0;
      end else begin
         case (wstate)
            W_IDLE: begin
               if (fifo_pop) begin
                  packet <= fifo_data;
                  wstate <= W_FIRST;
               end
            end
            W_FIRST: begin
               if (!stall) wstate <= W_SECOND;
            end
            W_SECOND: begin
               if (!stall) wstate <= W_IDLE;
            end
            default: wstate <= W_IDLE;
         endcase
      end
   end

   // Pointer and wrap; a software load beats a same-cycle advance
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         trace_pointer <= '0;
         trace_wrap <= 1'b0;
      end else if (pos_wr) begin
         trace_pointer <= pos_wdata;
         trace_wrap <= 1'b0;
      end else if (advance_now) begin
         trace_pointer <= stepped[PTR_W-1:0];
         if (stepped[PTR_W]) trace_wrap <= 1'b1;
      end
   end

   // Trace RAM single write port
   always_ff @(posedge clk_sys) begin
      if (bus_ram_wr) ram[bus_req.addr[RAM_AW+1:2]] <= bus_req.wdata;
      else if (wstate == W_FIRST) ram[trace_idx] <= packet.first;
      else if (wstate == W_SECOND) ram[trace_idx] <= packet.second;
   end

   // Bus answer one cycle after the request
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         bus_ack <= 1'b0;
         bus_rdata <= '0;
      end else begin
         bus_ack <= bus_req.valid;
         bus_rdata <= '0;
         if (bus_req.valid && !bus_req.write) begin
            if (bus_req.to_ram && ram_ok) bus_rdata <= ram[bus_req.addr[RAM_AW+1:2]];
            else if (reg_hit) bus_rdata <= master_value;
         end
      end
   end
endmodule

// *** logic/trace_pkg.sv ***
// Shared constants and carrier types for the trace buffer master control.
// Assumes a single system clock; pointer and flow settings arrive as levels.
package trace_pkg;
   // Pointer geometry: packet slots of two words, pointer bits 14..3
   localparam int PTR_W = 12;
   localparam int MASK_W = 5;
   localparam logic [4:0] MASK_MAX = 5'h0B;
   localparam int RAM_AW = 13;
   localparam int TRACE_RAM_WORDS = 8192;
   localparam int FIFO_DEPTH = 8;
   // Master control register location and layout
   localparam logic [14:0] MASTER_OFFSET = 15'h0004;
   localparam logic [31:0] MASTER_RESET = 32'h0000_0000;
   localparam int EN_BIT = 31;
   localparam int HALT_BIT = 9;
   localparam int RAM_PRIVILEGE_ONLY_BIT = 8;
   localparam int WPRIV_BIT = 7;
   localparam int STOPEN_BIT = 6;
   localparam int STARTEN_BIT = 5;
   localparam int HPROT_PRIV_BIT = 1;

   // One bus access, register or trace RAM
   typedef struct packed {
      logic valid;
      logic write;
      logic to_ram;
      logic [3:0] prot;
      logic [14:0] addr;
      logic [31:0] wdata;
   } bus_req_t;

   // One trace packet: first word, then second word
   typedef struct packed {
      logic [31:0] first;
      logic [31:0] second;
   } packet_t;

   typedef enum logic [1:0] {W_IDLE, W_FIRST, W_SECOND} write_state_t;
endpackage

// *** verification/pkt_source.sv ***
// Packet source standing in for the capture logic upstream.
// Offers packets up to a bench-set count; holds each until taken.
`timescale 1ns/1ps
module pkt_source
   import trace_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Bench control
   input wire logic [7:0] target,
   output logic [7:0] sent,
   // Packet stream
   output logic trace_valid,
   output packet_t trace_packet,
   input wire logic trace_ready
);
   // One process owns every output; released lines flip so stale data
   // never looks like a packet
   initial begin
      sent = 8'h00;
      trace_valid = 1'b0;
      trace_packet = '0;
      forever begin
         @(posedge clk_sys);
         if (trace_valid === 1'b1 && trace_ready === 1'b1) begin
            #1;
            trace_valid = 1'b0;
            trace_packet = ~trace_packet;
            sent = sent + 8'h01;
         end else if (!trace_valid && sent < target) begin
            #1;
            trace_valid = 1'b1;
            trace_packet = {32'hA000_0000 | 32'(sent), 32'hB000_0000 | 32'(sent)};
         end
      end
   end
endmodule

// *** verification/tb_top.sv ***
// Bench for the trace master control: register table, privilege, tracing.
// Inputs change 1 ns after each rising edge; packet source model upstream.
`timescale 1ns/1ps
module tb_top
   import trace_pkg::*;
();
   typedef struct packed {
      logic [3:0] wp;
      logic [31:0] wd;
      logic [3:0] rp;
      logic [31:0] exp;
   } row_t;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   bus_req_t bus_req = '0;
   logic bus_ack, trace_valid, trace_ready, trace_wrap, halt_out;
   logic [31:0] bus_rdata, rd;
   packet_t trace_packet;
   logic pos_wr = 1'b0, auto_stop = 1'b0, auto_halt = 1'b0;
   logic start_in = 1'b0, stop_in = 1'b0, dbg_en = 1'b0;
   logic [PTR_W-1:0] pos_wdata = '0, watermark = 12'hFFF, ptr;
   logic [7:0] target = 8'h00, sent;
   int failures = 0, cmp_count = 0;
   // Write then read back; user writes blocked only while bit 7 is set
   row_t rows [5] = '{'{4'h2, 32'hFFFF_FFFF, 4'h0, 32'h8000_03FF},
      '{4'h2, 32'h0000_0080, 4'h2, 32'h0000_0080}, '{4'h0, 32'h0000_001F, 4'h0, 32'h0000_0080},
      '{4'h2, 32'h0000_0000, 4'h0, 32'h0000_0000}, '{4'h0, 32'h0000_000C, 4'h2, 32'h0000_000C}};

   // 200 MHz clock
   always #2.5 clk_sys = ~clk_sys;

   trace_buffer_master_control dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req),
      .bus_ack(bus_ack), .bus_rdata(bus_rdata), .trace_valid(trace_valid),
      .trace_packet(trace_packet), .trace_ready(trace_ready), .pos_wr(pos_wr),
      .pos_wdata(pos_wdata), .watermark(watermark), .auto_stop(auto_stop),
      .auto_halt(auto_halt), .trace_pointer(ptr), .trace_wrap(trace_wrap),
      .trace_start_in(start_in), .trace_stop_in(stop_in), .invasive_debug_enable(dbg_en),
      .debug_halt_request_out(halt_out));
   pkt_source src_u (.clk_sys(clk_sys), .target(target), .sent(sent),
      .trace_valid(trace_valid), .trace_packet(trace_packet), .trace_ready(trace_ready));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // One access; request held one cycle, answer taken the cycle after
   task automatic bus(input logic wr, ram, input logic [3:0] p, input logic [14:0] a,
         input logic [31:0] wd);
      cyc(1);
      bus_req = '{1'b1, wr, ram, p, a, wd};
      cyc(1);
      bus_req.valid = 1'b0;
      chk("ack", 32'h1, {31'h0, bus_ack});
      rd = bus_rdata;
   endtask
   task automatic rdc(input string what, input logic ram, input logic [3:0] p,
         input logic [14:0] a, input logic [31:0] exp);
      bus(1'b0, ram, p, a, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic wr_m(input logic [3:0] p, input logic [31:0] d);
      bus(1'b1, 1'b0, p, MASTER_OFFSET, d);
   endtask
   task automatic load_ptr(input logic [PTR_W-1:0] v);
      pos_wdata = v;
      pos_wr = 1'b1;
      cyc(1);
      pos_wr = 1'b0;
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      cyc(10);
      rst_b = 1'b1;
      cyc(3);
      rdc("master reset", 1'b0, 4'h0, MASTER_OFFSET, MASTER_RESET);
      chk("ready", 32'h1, {31'h0, trace_ready});
      rdc("unmapped", 1'b0, 4'h2, 15'h0100, 32'h0);
      foreach (rows[i]) begin
         wr_m(rows[i].wp, rows[i].wd);
         rdc("master", 1'b0, rows[i].rp, MASTER_OFFSET, rows[i].exp);
      end
      $display("test registers done");
      wr_m(4'h2, 32'h0000_0100);
      bus(1'b1, 1'b1, 4'h2, 15'h0014, 32'hDEAD_BEEF);
      bus(1'b1, 1'b1, 4'h0, 15'h0014, 32'h1234_5678);
      rdc("ram user", 1'b1, 4'h0, 15'h0014, 32'h0);
      rdc("ram priv", 1'b1, 4'h2, 15'h0014, 32'hDEAD_BEEF);
      wr_m(4'h2, 32'h0);
      rdc("ram open", 1'b1, 4'h0, 15'h0014, 32'hDEAD_BEEF);
      $display("test privilege done");
      // Pointer set before any enable; buffer of four packets
      load_ptr(12'h004);
      wr_m(4'h2, 32'h0000_0021);
      target = 8'h08;
      cyc(30);
      chk("full", 32'h0, {31'h0, trace_ready});
      chk("held", 32'h4, {20'h0, ptr});
      start_in = 1'b1;
      cyc(1);
      start_in = 1'b0;
      cyc(40);
      chk("pointer", 32'h4, {20'h0, ptr});
      chk("wrap", 32'h1, {31'h0, trace_wrap});
      rdc("enabled", 1'b0, 4'h2, MASTER_OFFSET, 32'h8000_0021);
      for (int j = 4; j < 8; j++) begin
         rdc("first", 1'b1, 4'h2, 15'(j * 8), 32'hA000_0000 | j);
         rdc("second", 1'b1, 4'h2, 15'(j * 8 + 4), 32'hB000_0000 | j);
      end
      $display("test trace done");
      wr_m(4'h2, 32'h8000_0041);
      stop_in = 1'b1;
      cyc(6);
      stop_in = 1'b0;
      rdc("stopped", 1'b0, 4'h0, MASTER_OFFSET, 32'h0000_0041);
      $display("test stop done");
      wr_m(4'h2, 32'h0);
      watermark = 12'h002;
      auto_stop = 1'b1;
      auto_halt = 1'b1;
      dbg_en = 1'b1;
      load_ptr(12'h000);
      target = 8'h0B;
      wr_m(4'h2, 32'h8000_0001);
      cyc(20);
      chk("wm pointer", 32'h2, {20'h0, ptr});
      chk("halt out", 32'h1, {31'h0, halt_out});
      rdc("wm master", 1'b0, 4'h2, MASTER_OFFSET, 32'h0000_0201);
      wr_m(4'h2, 32'h0000_0221);
      start_in = 1'b1;
      cyc(8);
      chk("ignored start", 32'h2, {20'h0, ptr});
      dbg_en = 1'b0;
      cyc(2);
      chk("halt gated", 32'h0, {31'h0, halt_out});
      watermark = 12'h003;
      cyc(12);
      chk("restart", 32'h3, {20'h0, ptr});
      start_in = 1'b0;
      rdc("slot two", 1'b1, 4'h2, 15'h0010, 32'hA000_000A);
      $display("test watermark done");
      // Mask above the maximum wraps as the maximum: top slot rolls to zero
      auto_stop = 1'b0;
      auto_halt = 1'b0;
      load_ptr(12'hFFF);
      target = 8'h0C;
      wr_m(4'h2, 32'h8000_001F);
      cyc(10);
      chk("clamp pointer", 32'h0, {20'h0, ptr});
      chk("clamp wrap", 32'h1, {31'h0, trace_wrap});
      $display("test mask clamp done");
      // Mid-run reset: wrap, enable and ready return to their reset values
      rst_b = 1'b0;
      cyc(2);
      chk("ready in reset", 32'h0, {31'h0, trace_ready});
      rst_b = 1'b1;
      cyc(3);
      chk("reset ready", 32'h1, {31'h0, trace_ready});
      chk("reset pointer", 32'h0, {20'h0, ptr});
      chk("reset wrap", 32'h0, {31'h0, trace_wrap});
      chk("reset halt", 32'h0, {31'h0, halt_out});
      rdc("reset master", 1'b0, 4'h0, MASTER_OFFSET, MASTER_RESET);
      $display("test reset done");
      final_report();
   end

   // Watchdog: the run takes some 230 cycles, 10000 means a hang
   initial begin
      #50000;
      failures++;
      final_report();
   end
endmodule

// *** verification/trace_chk.sv ***
// Checker for the trace master control: bus, pointer and halt relations.
// Sees only top ports; mirrors the master bits that only software changes.
`timescale 1ns/1ps
module trace_chk
   import trace_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Bus
   input wire bus_req_t bus_req,
   input wire logic [31:0] bus_rdata,
   // Pointer and flow
   input wire logic pos_wr,
   input wire logic [PTR_W-1:0] pos_wdata,
   input wire logic [PTR_W-1:0] watermark,
   input wire logic auto_halt,
   input wire logic [PTR_W-1:0] trace_pointer,
   input wire logic trace_wrap,
   // Stop and debug
   input wire logic trace_stop_in,
   input wire logic invasive_debug_enable,
   input wire logic debug_halt_request_out
);
   logic [8:0] m;
   logic [4:0] eff;
   logic [12:0] span;
   logic [11:0] low;
   logic reg_rd;
   // Mirror of bits 8..0; user writes are blocked once bit 7 is set
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         m <= 9'h000;
      end else if (bus_req.valid && bus_req.write && !bus_req.to_ram
                   && bus_req.addr == MASTER_OFFSET
                   && (bus_req.prot[HPROT_PRIV_BIT] || !m[WPRIV_BIT])) begin
         m <= bus_req.wdata[8:0];
      end
   end
   // Wrap boundary; masks above the maximum clamp to it
   assign eff = (m[4:0] > MASK_MAX) ? MASK_MAX : m[4:0];
   assign span = (13'h0001 << (eff + 5'h01)) - 13'h0001;
   assign low = span[11:0];
   assign reg_rd = bus_req.valid && !bus_req.write && !bus_req.to_ram
                   && bus_req.addr == MASTER_OFFSET;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   AST_RSV: assert property (reg_rd |=> bus_rdata[30:10] == 21'h000000)
      else $error("reserved master bits not zero");
   AST_PRIV: assert property (reg_rd |=> bus_rdata[8:0] == $past(m))
      else $error("master low bits differ from permitted writes");
   AST_RAZ: assert property (bus_req.valid && bus_req.to_ram && !bus_req.write
      && !bus_req.prot[HPROT_PRIV_BIT] && m[RAM_PRIVILEGE_ONLY_BIT] |=> bus_rdata == 32'h0000_0000)
      else $error("user ram read not zero");
   AST_HALT_OUT: assert property (debug_halt_request_out |-> $past(invasive_debug_enable))
      else $error("halt output without debug enable");
   AST_HALT_WM: assert property (trace_pointer == watermark && auto_halt
      && invasive_debug_enable |=> debug_halt_request_out)
      else $error("watermark halt missing");
   AST_LOAD: assert property (pos_wr |=> trace_pointer == $past(pos_wdata) && !trace_wrap)
      else $error("pointer load wrong");
   AST_STEP: assert property (!$past(pos_wr) && $changed(trace_pointer) |->
      (trace_pointer & low) == (($past(trace_pointer) + 12'h001) & low)
      && (trace_pointer & ~low) == ($past(trace_pointer) & ~low))
      else $error("pointer step wrong");
   AST_WRAP: assert property ($rose(trace_wrap) |-> (trace_pointer & low) == 12'h000)
      else $error("wrap without zeroed low pointer bits");
   AST_STOP: assert property ((trace_stop_in && m[STOPEN_BIT] && !pos_wr) [*5]
      |-> $stable(trace_pointer))
      else $error("pointer moves while stopped");
endmodule

bind trace_buffer_master_control trace_chk chk_u (.*);
